// ==== adc_calibration_correction_bench.sv ====
// Purpose: self-checking bench of the aux_adc correction engine
// Assumes: trims change only between corrections
// Notes: expected codes come from a real-valued two-point model
`default_nettype none
module adc_calibration_correction_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk, i_arst_n, i_wb_cyc, i_wb_stb, i_wb_we, o_wb_ack, i_seq_valid, o_seq_ready, o_res_valid;
   logic [7:0] i_wb_adr;
   logic [31:0] i_wb_dat, o_wb_dat;
   logic [3:0] i_wb_sel;
   adccc_pkg::adccc_trim_t i_trim;
   adccc_pkg::adccc_req_t i_seq_req, o_res;
   int fails, checks;
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("MISMATCH at %0t got %h exp %h", $time, a, e); end end
   adccc_core dut_u (.i_mclk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel,
      .o_wb_dat, .o_wb_ack, .i_trim, .i_seq_valid, .i_seq_req, .o_seq_ready, .o_res_valid, .o_res);
   adccc_seq_model seq_u (.i_mclk, .o_valid(i_seq_valid), .o_req(i_seq_req), .i_ready(o_seq_ready),
      .i_res_valid(o_res_valid), .i_res(o_res));
   initial begin
      i_mclk = 1'b0;
      forever #50 i_mclk = ~i_mclk;
   end
   function automatic int sm(input int mag, input logic neg);
      return neg ? -mag : mag;
   endfunction
   function automatic logic [11:0] model_code(input logic [4:0] ch, input logic [11:0] a);
      int dev_lo, dev_hi, ref_lo, ref_hi;
      real k, y;
      ref_lo = 1441;
      ref_hi = 3276;
      dev_lo = sm(i_trim[3][4:0] * 4 + i_trim[1][2:1], i_trim[1][0]);
      dev_hi = sm(i_trim[4][5:0] * 4 + i_trim[2][2:1], i_trim[2][0]);
      case (ch)
         5'h07, 5'h12: begin
            dev_lo += sm(i_trim[5][6:1], i_trim[5][0]);
            dev_hi += sm(i_trim[6][7:1], i_trim[6][0]);
         end
         5'h08: begin
            dev_lo += sm(i_trim[8][4:3] * 16 + i_trim[7][4:1], i_trim[7][0]);
            dev_hi += sm(i_trim[10][4:0] * 4 + i_trim[8][2:1], i_trim[8][0]);
         end
         5'h09: begin
            dev_lo += sm(i_trim[14][4:3] * 16 + i_trim[12][4:1], i_trim[12][0]);
            dev_hi += sm(i_trim[16][4:0] * 4 + i_trim[14][2:1], i_trim[14][0]);
         end
         5'h0A: begin
            dev_lo = sm(i_trim[11][3:0] * 8 + i_trim[9][3:1], i_trim[9][0]);
            dev_hi = sm(i_trim[15][3:0] * 8 + i_trim[13][3:1], i_trim[13][0]);
            ref_lo = 150;
            ref_hi = 751;
         end
         default: ;
      endcase
      k = 1.0 + real'(dev_hi - dev_lo) / real'(ref_hi - ref_lo);
      y = (real'(a) - (dev_lo - (k - 1.0) * ref_lo)) / k;
      if (ch == 5'h11) y = real'(int'(a) - int'(i_trim[20])) * (1.0 + sm(i_trim[21][4:0], i_trim[21][5]) / 512.0);
      if (ch == 5'h0F || ch == 5'h10) y = a;
      // saturate, rounding past 4095 would wrap
      if (y < 0.0) return 12'h000;
      if (y >= 4094.5) return 12'hFFF;
      // small margin so exact halves round up despite real roundoff
      return 12'($rtoi(y + 0.5 + 1.0e-6));
   endfunction
   task automatic test_done;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
                     output logic [31:0] rd);
      int n;
      @(posedge i_mclk);
      i_wb_cyc <= 1'b1;
      i_wb_stb <= 1'b1;
      i_wb_we <= we;
      i_wb_adr <= adr;
      i_wb_dat <= dat;
      i_wb_sel <= sel;
      for (n = 0; n < 20; n++) begin
         @(posedge i_mclk);
         if (o_wb_ack === 1'b1) break;
      end
      rd = o_wb_dat;
      i_wb_cyc <= 1'b0;
      i_wb_stb <= 1'b0;
      i_wb_we <= 1'b0;
      if (n == 20) begin
         fails++;
         test_done();
      end
   endtask
   task automatic conv(input logic [4:0] ch, input logic [11:0] raw, input int gap);
      adccc_pkg::adccc_req_t res;
      logic ok;
      seq_u.convert(ch, raw, gap, res, ok);
      `CHK(ok, 1'b1)
      if (!ok) test_done();
      `CHK(res.chan, ch)
      `CHK(res.raw, model_code(ch, raw))
   endtask
   task automatic t_reset;
      logic [31:0] rd;
      `CHK(o_seq_ready, 1'b1)
      `CHK(o_res, 17'h00000)
      wb(1'b0, 8'h04, 32'h0, 4'hF, rd);
      `CHK(rd, 32'h00000000)
      wb(1'b0, 8'h0C, 32'h0, 4'hF, rd);
      `CHK(rd, 32'h00000000)
      $display("t_reset done");
   endtask
   task automatic t_chans(input logic [7:0] mul, input logic [7:0] add);
      logic [11:0] raws [4] = '{12'h000, 12'h5A1, 12'hCCC, 12'hFFF};
      @(posedge i_mclk);
      for (int n = 0; n < 22; n++) i_trim[n] <= 8'(n * mul + add);
      for (int c = 0; c < 19; c++) begin
         for (int r = 0; r < 4; r++) conv(5'(c), raws[r], r);
      end
      $display("t_chans done");
   endtask
   task automatic t_bus;
      logic [31:0] rd;
      int n;
      wb(1'b1, 8'h08, 32'h00000002, 4'hF, rd);
      wb(1'b1, 8'h00, 32'h000A07D0, 4'h7, rd);
      wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
      `CHK(rd[1:0], 2'b00)
      wb(1'b1, 8'h00, 32'h000A07D0, 4'hF, rd);
      for (n = 0; n < 40; n++) begin
         wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
         if (rd[1] === 1'b1) break;
      end
      `CHK(rd[3:0], 4'b0010)
      if (n == 40) test_done();
      wb(1'b0, 8'h04, 32'h0, 4'hF, rd);
      `CHK(rd, {11'h000, 5'h0A, 4'h0, model_code(5'h0A, 12'h7D0)})
      wb(1'b1, 8'h08, 32'h00000002, 4'hF, rd);
      wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
      `CHK(rd[1], 1'b0)
      // raw zero below the nonzero trim20 offset must clamp to zero
      wb(1'b1, 8'h00, 32'h00110000, 4'hF, rd);
      for (n = 0; n < 40; n++) begin
         wb(1'b0, 8'h08, 32'h0, 4'hF, rd);
         if (rd[1] === 1'b1) break;
      end
      `CHK(rd[3:0], 4'b0110)
      if (n == 40) test_done();
      wb(1'b0, 8'h04, 32'h0, 4'hF, rd);
      `CHK(rd, {11'h000, 5'h11, 4'h0, model_code(5'h11, 12'h000)})
      $display("t_bus done");
   endtask
   initial begin
      fails = 0;
      checks = 0;
      i_arst_n = 1'b0;
      i_wb_cyc = 1'b0;
      i_wb_stb = 1'b0;
      i_wb_we = 1'b0;
      i_wb_adr = 8'h00;
      i_wb_dat = 32'h00000000;
      i_wb_sel = 4'h0;
      i_trim = '0;
      repeat (3) @(posedge i_mclk);
      i_arst_n <= 1'b1;
      t_reset();
      t_chans(8'h1D, 8'h05);
      t_chans(8'h3B, 8'h02);
      t_bus();
      test_done();
   end
endmodule // adc_calibration_correction_bench
`default_nettype wire

// ==== adccc_core.sv ====
// Purpose: per-channel two-point correction of raw aux_adc codes
// Assumes: trim bytes are static while a correction runs; one request at a time
// Notes: gain and offset are folded into one rational expression so a single
//        division gives the corrected code with round-to-nearest
`default_nettype none
module adccc_core (
   input wire logic i_mclk, // system clock, 10 MHz
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_wb_cyc, // wishbone cycle
   input wire logic i_wb_stb, // wishbone strobe
   input wire logic i_wb_we, // wishbone write enable
   input wire logic [7:0] i_wb_adr, // wishbone byte address
   input wire logic [31:0] i_wb_dat, // wishbone write data
   input wire logic [3:0] i_wb_sel, // wishbone byte selects
   output logic [31:0] o_wb_dat, // wishbone read data
   output logic o_wb_ack, // wishbone acknowledge
   input wire adccc_pkg::adccc_trim_t i_trim, // adc_cal_trim_n bytes
   input wire logic i_seq_valid, // sequencer request strobe
   input wire adccc_pkg::adccc_req_t i_seq_req, // sequencer raw code and channel
   output logic o_seq_ready, // engine idle, request taken
   output logic o_res_valid, // corrected code ready, pulse
   output adccc_pkg::adccc_req_t o_res // corrected code and channel
);
   adccc_pkg::adccc_state_t state_r;
   adccc_pkg::adccc_req_t req_r;
   logic ack_r;
   logic done_r;
   logic sat_r;
   logic err_r;
   logic bus_req;
   logic bus_wr;
   logic bus_start;
   logic take_seq;
   logic take_any;
   logic div_busy;
   logic div_done;
   logic [adccc_pkg::NUM_W-1:0] div_quot;
   logic signed [10:0] dev1;
   logic signed [10:0] dev2;
   logic signed [10:0] gain17;
   logic [12:0] ref_lo;
   logic [12:0] ref_hi;
   logic use_cur;
   logic use_raw;
   logic signed [27:0] raw_s;
   logic signed [27:0] num_s;
   logic signed [27:0] den_s;
   logic signed [27:0] num_rnd;
   logic den_bad;
   logic num_neg;
   logic [11:0] code_nxt;
   logic sat_nxt;

   // signed datapath below is hand-sized for these widths
   if (adccc_pkg::NUM_W != 28 || adccc_pkg::DEN_W != 13 || adccc_pkg::CODE_W != 12) begin : g_width_check
      $error("adccc_core: package widths do not match the datapath");
   end

   // sign-magnitude decode, sign bit set means negative
   function automatic logic signed [10:0] sm_dev(input logic [8:0] mag, input logic neg);
      logic signed [10:0] v;
      v = signed'({2'b00, mag});
      return neg ? -v : v;
   endfunction

   function automatic logic signed [27:0] sx28(input logic signed [10:0] v);
      return {{17{v[10]}}, v};
   endfunction

   assign bus_req = i_wb_cyc && i_wb_stb && !ack_r;
   assign bus_wr = bus_req && i_wb_we;
   assign o_seq_ready = (state_r == adccc_pkg::ST_IDLE);
   assign take_seq = o_seq_ready && i_seq_valid;
   // full-word write only; a partial write could start on a torn code
   assign bus_start = bus_wr && (i_wb_adr[7:2] == adccc_pkg::REG_REQ[7:2]) && (i_wb_sel == 4'hF)
                      && o_seq_ready && !i_seq_valid;
   assign take_any = take_seq || bus_start;

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end
   assign o_wb_ack = ack_r;

   // read data registered with the ack; unmapped offsets read zero
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_wb_dat <= adccc_pkg::RESET_WORD;
      end else if (bus_req && !i_wb_we) begin
         o_wb_dat <= adccc_pkg::RESET_WORD;
         case (i_wb_adr[7:2])
            adccc_pkg::REG_REQ[7:2]: begin
               o_wb_dat[adccc_pkg::REQ_RAW_LSB +: 12] <= req_r.raw;
               o_wb_dat[adccc_pkg::REQ_CH_LSB +: 5] <= req_r.chan;
            end
            adccc_pkg::REG_RES[7:2]: begin
               o_wb_dat[adccc_pkg::RES_CODE_LSB +: 12] <= o_res.raw;
               o_wb_dat[adccc_pkg::RES_CH_LSB +: 5] <= o_res.chan;
            end
            adccc_pkg::REG_STAT[7:2]: begin
               o_wb_dat[adccc_pkg::STAT_BUSY] <= !o_seq_ready;
               o_wb_dat[adccc_pkg::STAT_DONE] <= done_r;
               o_wb_dat[adccc_pkg::STAT_SAT] <= sat_r;
               o_wb_dat[adccc_pkg::STAT_ERR] <= err_r;
            end
            default: begin
               o_wb_dat <= adccc_pkg::RESET_WORD;
            end
         endcase
      end
   end

   // request capture; sequencer wins over a same-cycle bus start
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_r <= '0;
      end else if (take_seq) begin
         req_r <= i_seq_req;
      end else if (bus_start) begin
         req_r.raw <= i_wb_dat[adccc_pkg::REQ_RAW_LSB +: 12];
         req_r.chan <= i_wb_dat[adccc_pkg::REQ_CH_LSB +: 5];
      end
   end

   // per-channel deviations from trim bytes
   always_comb begin
      ref_lo = adccc_pkg::REF_LO_COMMON;
      ref_hi = adccc_pkg::REF_HI_COMMON;
      use_cur = 1'b0;
      use_raw = 1'b0;
      dev1 = sm_dev({2'b00, i_trim[3][4:0], i_trim[1][2:1]}, i_trim[1][0]);
      dev2 = sm_dev({1'b0, i_trim[4][5:0], i_trim[2][2:1]}, i_trim[2][0]);
      gain17 = sm_dev({4'h0, i_trim[21][4:0]}, i_trim[21][5]);
      case (req_r.chan)
         5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0B, 5'h0C, 5'h0D, 5'h0E: begin
            use_raw = 1'b0;
         end
         adccc_pkg::CH_BACKUP: begin
            dev1 = dev1 + sm_dev({3'b000, i_trim[8][4:3], i_trim[7][4:1]}, i_trim[7][0]);
            dev2 = dev2 + sm_dev({2'b00, i_trim[10][4:0], i_trim[8][2:1]}, i_trim[8][0]);
         end
         adccc_pkg::CH_CHARGER: begin
            dev1 = dev1 + sm_dev({3'b000, i_trim[14][4:3], i_trim[12][4:1]}, i_trim[12][0]);
            dev2 = dev2 + sm_dev({2'b00, i_trim[16][4:0], i_trim[14][2:1]}, i_trim[14][0]);
         end
         adccc_pkg::CH_VBUS: begin
            ref_lo = adccc_pkg::REF_LO_VBUS;
            ref_hi = adccc_pkg::REF_HI_VBUS;
            dev1 = sm_dev({2'b00, i_trim[11][3:0], i_trim[9][3:1]}, i_trim[9][0]);
            dev2 = sm_dev({2'b00, i_trim[15][3:0], i_trim[13][3:1]}, i_trim[13][0]);
         end
         adccc_pkg::CH_SYS, adccc_pkg::CH_BAT: begin
            dev1 = dev1 + sm_dev({3'b000, i_trim[5][6:1]}, i_trim[5][0]);
            dev2 = dev2 + sm_dev({2'b00, i_trim[6][7:1]}, i_trim[6][0]);
         end
         adccc_pkg::CH_CHG_CUR: begin
            use_cur = 1'b1;
         end
         default: begin
            // test channels carry no calibration
            use_raw = 1'b1;
         end
      endcase
   end

   // fraction for the divider
   always_comb begin
      raw_s = signed'({16'h0000, req_r.raw});
      if (use_cur) begin
         // code part of charge current; volts and resistor scaling left to software
         num_s = (raw_s - signed'({20'h00000, i_trim[20]})) * (signed'({15'h0000, adccc_pkg::CUR_GAIN_DEN})
                 + sx28(gain17));
         den_s = signed'({15'h0000, adccc_pkg::CUR_GAIN_DEN});
      end else if (use_raw) begin
         num_s = raw_s;
         den_s = 28'sh0000001;
      end else begin
         // (a-b)/k, k=1+dD/dX, b=dev1-(k-1)*ref_lo, scaled by dX
         num_s = (raw_s - sx28(dev1)) * signed'({15'h0000, ref_hi - ref_lo})
                 + (sx28(dev2) - sx28(dev1)) * signed'({15'h0000, ref_lo});
         den_s = signed'({15'h0000, ref_hi - ref_lo}) + sx28(dev2) - sx28(dev1);
      end
      // round to nearest keeps error under half a code
      num_rnd = num_s + (den_s >>> 1);
      den_bad = (den_s < 28'sh0000001) || (den_s > 28'sh0000FFF);
      num_neg = num_rnd[27];
   end

   adccc_div #(
      .NUM_W(adccc_pkg::NUM_W),
      .DEN_W(adccc_pkg::DEN_W)
   ) u_div (
      .i_mclk(i_mclk),
      .i_arst_n(i_arst_n),
      .i_start((state_r == adccc_pkg::ST_CALC) && !den_bad && !num_neg),
      .i_num(num_rnd),
      .i_den(den_s[adccc_pkg::DEN_W-1:0]),
      .o_busy(div_busy),
      .o_done(div_done),
      .o_quot(div_quot)
   );

   always_comb begin
      sat_nxt = 1'b0;
      code_nxt = div_quot[11:0];
      if (div_quot > {16'h0000, adccc_pkg::CODE_MAX}) begin
         code_nxt = adccc_pkg::CODE_MAX;
         sat_nxt = 1'b1;
      end
   end

   // sequencing: idle, load divider, wait, publish
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= adccc_pkg::ST_IDLE;
      end else begin
         case (state_r)
            adccc_pkg::ST_IDLE: begin
               if (take_any) begin
                  state_r <= adccc_pkg::ST_CALC;
               end
            end
            adccc_pkg::ST_CALC: begin
               state_r <= (den_bad || num_neg) ? adccc_pkg::ST_FIN : adccc_pkg::ST_DIV;
            end
            adccc_pkg::ST_DIV: begin
               if (div_done) begin
                  state_r <= adccc_pkg::ST_FIN;
               end else if (!div_busy) begin
                  // divider idle without a result: leave rather than hang
                  state_r <= adccc_pkg::ST_FIN;
               end
            end
            adccc_pkg::ST_FIN: begin
               state_r <= adccc_pkg::ST_IDLE;
            end
            default: begin
               state_r <= adccc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // result register; a negative result clamps to zero
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_res <= '0;
         o_res_valid <= 1'b0;
         sat_r <= 1'b0;
         err_r <= 1'b0;
      end else begin
         o_res_valid <= 1'b0;
         if (state_r == adccc_pkg::ST_CALC && den_bad) begin
            // unusable trim: pass the raw code through and flag it
            o_res <= req_r;
            sat_r <= 1'b0;
            err_r <= 1'b1;
         end else if (state_r == adccc_pkg::ST_CALC && num_neg) begin
            o_res.raw <= 12'h000;
            o_res.chan <= req_r.chan;
            sat_r <= 1'b1;
            err_r <= 1'b0;
         end else if (state_r == adccc_pkg::ST_DIV && div_done) begin
            o_res.raw <= code_nxt;
            o_res.chan <= req_r.chan;
            sat_r <= sat_nxt;
            err_r <= 1'b0;
         end else if (state_r == adccc_pkg::ST_DIV && !div_busy) begin
            // lost division: raw code passed through and flagged
            o_res <= req_r;
            sat_r <= 1'b0;
            err_r <= 1'b1;
         end
         if (state_r == adccc_pkg::ST_FIN) begin
            o_res_valid <= 1'b1;
         end
      end
   end

   // done flag: write one to clear, a same-cycle completion wins
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         done_r <= 1'b0;
      end else if (state_r == adccc_pkg::ST_FIN) begin
         done_r <= 1'b1;
      end else if (bus_wr && i_wb_adr[7:2] == adccc_pkg::REG_STAT[7:2] && i_wb_sel[0]
                   && i_wb_dat[adccc_pkg::STAT_DONE]) begin
         done_r <= 1'b0;
      end
   end
endmodule // adccc_core
`default_nettype wire

// ==== adccc_core_checker.sv ====
// Purpose: port timing checks of the correction engine
// Assumes: one clock domain, one correction in flight
// Notes: bound to adccc_core after the module
`default_nettype none
module adccc_core_checker (
   input wire logic i_mclk, // clock
   input wire logic i_arst_n, // reset, active low
   input wire logic i_wb_cyc, // bus cycle
   input wire logic i_wb_stb, // bus strobe
   input wire logic o_wb_ack, // bus ack
   input wire logic i_seq_valid, // request strobe
   input wire adccc_pkg::adccc_req_t i_seq_req, // request
   input wire logic o_seq_ready, // engine idle
   input wire logic o_res_valid, // result strobe
   input wire adccc_pkg::adccc_req_t o_res // result
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_arst_n);
   adccc_pkg::adccc_req_t req_r;
   logic from_seq_r;
   // bus-started results carry no sequencer request to compare with
   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         req_r <= '0;
         from_seq_r <= 1'b0;
      end else if (i_seq_valid && o_seq_ready) begin
         req_r <= i_seq_req;
         from_seq_r <= 1'b1;
      end else if (o_res_valid) begin
         from_seq_r <= 1'b0;
      end
   end
   sequence s_take;
      i_seq_valid && o_seq_ready;
   endsequence
   sequence s_answer;
      !o_res_valid ##[1:31] o_res_valid;
   endsequence
   property p_answer;
      s_take |=> s_answer;
   endproperty
   property p_hold;
      s_take |=> !o_seq_ready until o_res_valid;
   endproperty
   property p_ready;
      o_res_valid |-> o_seq_ready;
   endproperty
   property p_pulse;
      o_res_valid |=> !o_res_valid;
   endproperty
   property p_chan;
      o_res_valid && from_seq_r |-> o_res.chan == req_r.chan;
   endproperty
   property p_moves;
      $changed(o_res) |=> o_res_valid;
   endproperty
   property p_ack;
      i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack;
   endproperty
   property p_ack_cause;
      $rose(o_wb_ack) |-> $past(i_wb_cyc) && $past(i_wb_stb);
   endproperty
   a_answer: assert property (p_answer) else $error("result late");
   a_hold: assert property (p_hold) else $error("ready while busy");
   a_ready: assert property (p_ready) else $error("not idle at result");
   a_pulse: assert property (p_pulse) else $error("result strobe long");
   a_chan: assert property (p_chan) else $error("wrong channel");
   a_moves: assert property (p_moves) else $error("result moved alone");
   a_ack: assert property (p_ack) else $error("bad ack timing");
   a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
endmodule // adccc_core_checker
bind adccc_core adccc_core_checker chk_u (.i_mclk, .i_arst_n, .i_wb_cyc, .i_wb_stb, .o_wb_ack, .i_seq_valid,
   .i_seq_req, .o_seq_ready, .o_res_valid, .o_res);
`default_nettype wire

// ==== adccc_div.sv ====
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: denominator is non-zero when i_start is given
// Notes: quotient stands in o_quot from o_done until the next start
`default_nettype none
module adccc_div #(
   parameter int unsigned NUM_W = 28,
   parameter int unsigned DEN_W = 13
) (
   input wire logic i_mclk, // system clock
   input wire logic i_arst_n, // async reset, active low
   input wire logic i_start, // load operands, pulse
   input wire logic [NUM_W-1:0] i_num, // dividend
   input wire logic [DEN_W-1:0] i_den, // divisor
   output logic o_busy, // division running
   output logic o_done, // quotient ready, pulse
   output logic [NUM_W-1:0] o_quot // quotient
);
   localparam int unsigned CNT_W = $clog2(NUM_W + 1);

   // refused at elaboration: the remainder must be narrower than the dividend
   if (NUM_W <= DEN_W || DEN_W < 2) begin : g_width_check
      $error("adccc_div: NUM_W must exceed DEN_W and DEN_W must be at least 2");
   end

   logic [DEN_W:0] rem_r;
   logic [DEN_W:0] rem_sh;
   logic [DEN_W-1:0] den_r;
   logic [CNT_W-1:0] cnt_r;
   logic fits;

   assign rem_sh = {rem_r[DEN_W-1:0], o_quot[NUM_W-1]};
   assign fits = rem_sh >= {1'b0, den_r};

   always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rem_r <= '0;
         den_r <= '0;
         cnt_r <= '0;
         o_quot <= '0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
      end else begin
         o_done <= 1'b0;
         if (i_start) begin
            rem_r <= '0;
            den_r <= i_den;
            o_quot <= i_num;
            cnt_r <= CNT_W'(NUM_W);
            o_busy <= 1'b1;
         end else if (o_busy) begin
            rem_r <= fits ? rem_sh - {1'b0, den_r} : rem_sh;
            o_quot <= {o_quot[NUM_W-2:0], fits};
            cnt_r <= cnt_r - CNT_W'(1);
            if (cnt_r == CNT_W'(1)) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
            end
         end
      end
   end
endmodule // adccc_div
`default_nettype wire

// ==== adccc_pkg.sv ====
// Purpose: shared constants and types of the aux_adc calibration correction block
// Assumes: 12-bit raw codes, trim bytes held static by the one-time-programmable store
// Notes: register offsets are byte addresses on a 32-bit classic Wishbone bus
`default_nettype none
package adccc_pkg;
   // code range
   localparam int unsigned CODE_W = 12;
   localparam logic [11:0] CODE_MAX = 12'hFFF;
   localparam int unsigned CHAN_W = 5;
   localparam int unsigned TRIM_N = 22;
   // fixed reference codes
   localparam logic [12:0] REF_LO_COMMON = 13'h05A1;
   localparam logic [12:0] REF_HI_COMMON = 13'h0CCC;
   localparam logic [12:0] REF_LO_VBUS = 13'h0096;
   localparam logic [12:0] REF_HI_VBUS = 13'h02EF;
   // channel numbers with their own formulas
   localparam logic [4:0] CH_BACKUP = 5'h08;
   localparam logic [4:0] CH_CHARGER = 5'h09;
   localparam logic [4:0] CH_VBUS = 5'h0A;
   localparam logic [4:0] CH_SYS = 5'h07;
   localparam logic [4:0] CH_BAT = 5'h12;
   localparam logic [4:0] CH_CHG_CUR = 5'h11;
   // charge current gain trim scale
   localparam logic [12:0] CUR_GAIN_DEN = 13'h0200;
   // divider sizing
   localparam int unsigned NUM_W = 28;
   localparam int unsigned DEN_W = 13;
   // register map
   localparam logic [7:0] REG_REQ = 8'h00;
   localparam logic [7:0] REG_RES = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam int unsigned REQ_RAW_LSB = 0;
   localparam int unsigned REQ_CH_LSB = 16;
   localparam int unsigned RES_CODE_LSB = 0;
   localparam int unsigned RES_CH_LSB = 16;
   localparam int unsigned STAT_BUSY = 0;
   localparam int unsigned STAT_DONE = 1;
   localparam int unsigned STAT_SAT = 2;
   localparam int unsigned STAT_ERR = 3;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   typedef struct packed {
      logic [4:0] chan;
      logic [11:0] raw;
   } adccc_req_t;

   // element n is adc_cal_trim_n
   typedef logic [TRIM_N-1:0][7:0] adccc_trim_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CALC = 2'b01,
      ST_DIV = 2'b10,
      ST_FIN = 2'b11
   } adccc_state_t;
endpackage : adccc_pkg
`default_nettype wire

// ==== adccc_seq_model.sv ====
// Purpose: conversion sequencer feeding raw codes to the engine
// Assumes: request held until taken
// Notes: released data lines show the inverse of the last value
`default_nettype none
module adccc_seq_model (
   input wire logic i_mclk, // clock
   output logic o_valid, // request strobe
   output adccc_pkg::adccc_req_t o_req, // request
   input wire logic i_ready, // engine idle
   input wire logic i_res_valid, // result strobe
   input wire adccc_pkg::adccc_req_t i_res // result
);
   initial begin
      o_valid = 1'b0;
      o_req = '0;
   end
   task automatic convert(input logic [4:0] ch, input logic [11:0] raw, input int gap,
                          output adccc_pkg::adccc_req_t res, output logic ok);
      int n;
      ok = 1'b0;
      res = '0;
      repeat (gap) @(posedge i_mclk);
      o_valid <= 1'b1;
      o_req <= '{chan: ch, raw: raw};
      for (n = 0; n < 50; n++) begin
         @(posedge i_mclk);
         if (i_ready === 1'b1) break;
      end
      o_valid <= 1'b0;
      o_req <= ~o_req;
      for (n = 0; n < 50; n++) begin
         @(posedge i_mclk);
         if (i_res_valid === 1'b1) begin
            res = i_res;
            ok = 1'b1;
            break;
         end
      end
   endtask
endmodule // adccc_seq_model
`default_nettype wire
